// [refresh_timer_pkg.sv]
// Package with register map, field layout and types of the refresh timer
package refresh_timer_pkg;

    // Byte addresses of the register words
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_COUNTER = 8'h04;
    localparam logic [7:0] ADDR_PERIOD = 8'h08;
    localparam logic [7:0] ADDR_ACCESS = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;

    // Control and access register field positions
    localparam int MATCH_FLAG_BIT = 15;
    localparam int MATCH_IRQ_EN_BIT = 14;
    localparam int CAS_RAS_WAIT_LSB = 12;
    localparam int CLK_SEL_LSB = 8;
    localparam int REFRESH_EN_BIT = 7;
    localparam int PARALLEL_BIT = 6;
    localparam int REFRESH_WAIT_LSB = 4;
    localparam int SELF_REF_BIT = 3;
    localparam int POST_PRE_LSB = 0;
    localparam int PRECHARGE_LSB = 12;
    localparam int SDRAM_SPACE_BIT = 0;

    // Reset values
    localparam logic [7:0] COUNTER_RESET = 8'h00;
    localparam logic [7:0] PERIOD_RESET = 8'hff;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;

    // Divider: one step per prescale ratio, 4096 is the largest
    localparam int PRESCALE_W = 12;
    localparam logic [2:0] CLK_SEL_HALT = 3'h0;

    // One refresh cycle walks through these phases
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CAS,
        ST_CAS_RAS_WAIT,
        ST_RAS,
        ST_PRECHARGE
    } refresh_state_t;

    // Module state apart from the standby synchronisers
    typedef struct packed {
        logic [15:0] control_r;
        logic [7:0] counter_r;
        logic [7:0] period_r;
        logic [1:0] precharge_r;
        logic sdram_space_r;
        logic [11:0] prescale_r;
        logic pending_r;
        logic flag_seen_r;
        logic standby_seen_r;
        logic extra_pre_r;
        refresh_state_t state_r;
        logic [3:0] wait_cnt_r;
        logic ahb_sel_r;
        logic ahb_write_r;
        logic [7:0] ahb_addr_r;
        logic [31:0] rdata_r;
    } timer_state_t;

    // Strobes towards the memory port
    typedef struct packed {
        logic cas;
        logic ras;
        logic precharge;
        logic self_refresh;
        logic hold_other;
        logic busy;
    } refresh_strobe_t;

endpackage

// [dram_refresh_timer.sv]
// DRAM refresh timer with counter, period compare and refresh sequencer
`timescale 1ns/1ps
`default_nettype none

module dram_refresh_timer
    import refresh_timer_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Standby controls from the power manager
    input wire logic hw_standby_i,
    input wire logic sw_standby_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [7:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // External bus arbitration
    input wire logic bus_grant_i,
    output logic bus_request_o,
    // Memory strobes and interrupt
    output refresh_strobe_t strobe_o,
    output logic match_irq_o
);

    timer_state_t s_r;
    timer_state_t s_nxt;

    // Synchronised standby inputs, they come from another power domain
    logic [1:0] hw_sync_r;
    logic [1:0] sw_sync_r;
    logic hw_standby;
    logic sw_standby;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            hw_sync_r <= 2'h0;
            sw_sync_r <= 2'h0;
        end else begin
            hw_sync_r <= {hw_sync_r[0], hw_standby_i};
            sw_sync_r <= {sw_sync_r[0], sw_standby_i};
        end
    end
    assign hw_standby = hw_sync_r[1];
    assign sw_standby = sw_sync_r[1];

    // Decoded control fields and signals derived from the state
    logic [2:0] clk_sel;
    logic refresh_en;
    logic [1:0] cas_ras_wait;
    logic [1:0] refresh_wait;
    logic [2:0] post_pre;
    logic tick;
    logic match;
    logic wr_access;
    logic [3:0] pre_len;

    assign clk_sel = s_r.control_r[CLK_SEL_LSB +: 3];
    assign refresh_en = s_r.control_r[REFRESH_EN_BIT];
    assign cas_ras_wait = s_r.control_r[CAS_RAS_WAIT_LSB +: 2];
    assign refresh_wait = s_r.control_r[REFRESH_WAIT_LSB +: 2];
    assign post_pre = s_r.control_r[POST_PRE_LSB +: 3];
    assign match = (s_r.counter_r == s_r.period_r);
    assign wr_access = s_r.ahb_sel_r && s_r.ahb_write_r;
    // Precharge length in states, minus one for the down-count
    assign pre_len = {2'h0, s_r.precharge_r} +
        (s_r.extra_pre_r ? {1'b0, post_pre} : 4'h0);

    // Prescale taps: phi/2, /8, /32, /128, /512, /2048, /4096
    always_comb begin
        unique case (clk_sel)
            3'h1: tick = s_r.prescale_r[0];
            3'h2: tick = &s_r.prescale_r[2:0];
            3'h3: tick = &s_r.prescale_r[4:0];
            3'h4: tick = &s_r.prescale_r[6:0];
            3'h5: tick = &s_r.prescale_r[8:0];
            3'h6: tick = &s_r.prescale_r[10:0];
            3'h7: tick = &s_r.prescale_r[11:0];
            default: tick = 1'b0;
        endcase
    end

    // Next state of everything
    always_comb begin
        s_nxt = s_r;
        s_nxt.prescale_r = s_r.prescale_r + 12'h001;

        // Counter advances or matches; the match takes priority
        if (match) begin
            s_nxt.counter_r = COUNTER_RESET;
            s_nxt.control_r[MATCH_FLAG_BIT] = 1'b1;
            if (refresh_en) begin
                s_nxt.pending_r = 1'b1;
            end
        end else if (tick && clk_sel != CLK_SEL_HALT) begin
            s_nxt.counter_r = s_r.counter_r + 8'h01;
        end

        // Remember that software saw the flag at one
        if (s_r.ahb_sel_r && !s_r.ahb_write_r &&
                s_r.ahb_addr_r == ADDR_CONTROL &&
                s_r.control_r[MATCH_FLAG_BIT]) begin
            s_nxt.flag_seen_r = 1'b1;
        end

        // Register writes; a fresh match still wins over a clear
        if (wr_access) begin
            unique case (s_r.ahb_addr_r)
                ADDR_CONTROL: begin
                    s_nxt.control_r[13:0] = hwdata_i[13:0];
                    if (refresh_en || hwdata_i[REFRESH_EN_BIT]) begin
                        s_nxt.control_r[MATCH_IRQ_EN_BIT] = 1'b0;
                    end else begin
                        s_nxt.control_r[MATCH_IRQ_EN_BIT] =
                            hwdata_i[MATCH_IRQ_EN_BIT];
                    end
                    if (!hwdata_i[MATCH_FLAG_BIT] && !refresh_en &&
                            s_r.flag_seen_r && !match) begin
                        s_nxt.control_r[MATCH_FLAG_BIT] = 1'b0;
                        s_nxt.flag_seen_r = 1'b0;
                    end
                end
                ADDR_COUNTER: if (!match) begin
                    s_nxt.counter_r = hwdata_i[7:0];
                end
                ADDR_PERIOD: s_nxt.period_r = hwdata_i[7:0];
                ADDR_ACCESS: begin
                    s_nxt.precharge_r = hwdata_i[PRECHARGE_LSB +: 2];
                    s_nxt.sdram_space_r = hwdata_i[SDRAM_SPACE_BIT];
                end
                default: ;
            endcase
        end

        // Self refresh bit clears once software standby is left
        s_nxt.standby_seen_r = sw_standby;
        if (s_r.standby_seen_r && !sw_standby) begin
            if (s_r.control_r[SELF_REF_BIT] && refresh_en) begin
                s_nxt.extra_pre_r = 1'b1;
            end
            s_nxt.control_r[SELF_REF_BIT] = 1'b0;
        end

        // Refresh sequencer
        unique case (s_r.state_r)
            ST_IDLE: begin
                if (s_r.extra_pre_r) begin
                    s_nxt.state_r = ST_PRECHARGE;
                    s_nxt.wait_cnt_r = pre_len;
                end else if (s_r.pending_r && bus_grant_i &&
                        !sw_standby) begin
                    s_nxt.pending_r = 1'b0;
                    s_nxt.state_r = ST_CAS;
                    s_nxt.wait_cnt_r = {2'h0, cas_ras_wait};
                    // Flag clears when the CBR refresh executes
                    if (!match) begin
                        s_nxt.control_r[MATCH_FLAG_BIT] = 1'b0;
                    end
                end
            end
            ST_CAS: begin
                s_nxt.state_r = (s_r.wait_cnt_r == 4'h0) ?
                    ST_RAS : ST_CAS_RAS_WAIT;
                s_nxt.wait_cnt_r = s_r.wait_cnt_r - 4'h1;
                if (s_r.wait_cnt_r == 4'h0) begin
                    s_nxt.wait_cnt_r = {2'h0, refresh_wait};
                end
            end
            ST_CAS_RAS_WAIT: begin
                if (s_r.wait_cnt_r == 4'h0) begin
                    s_nxt.state_r = ST_RAS;
                    s_nxt.wait_cnt_r = {2'h0, refresh_wait};
                end else begin
                    s_nxt.wait_cnt_r = s_r.wait_cnt_r - 4'h1;
                end
            end
            ST_RAS: begin
                if (s_r.wait_cnt_r == 4'h0) begin
                    s_nxt.state_r = ST_PRECHARGE;
                    s_nxt.wait_cnt_r = pre_len;
                end else begin
                    s_nxt.wait_cnt_r = s_r.wait_cnt_r - 4'h1;
                end
            end
            ST_PRECHARGE: begin
                if (s_r.wait_cnt_r == 4'h0) begin
                    s_nxt.state_r = ST_IDLE;
                    s_nxt.extra_pre_r = 1'b0;
                end else begin
                    s_nxt.wait_cnt_r = s_r.wait_cnt_r - 4'h1;
                end
            end
            default: s_nxt.state_r = ST_IDLE;
        endcase

        // Interrupt enable cannot survive refresh mode
        if (s_nxt.control_r[REFRESH_EN_BIT]) begin
            s_nxt.control_r[MATCH_IRQ_EN_BIT] = 1'b0;
        end

        // Bus address phase capture, zero wait states
        s_nxt.ahb_sel_r = hsel_i && hready_i && htrans_i[1];
        s_nxt.ahb_write_r = hwrite_i;
        s_nxt.ahb_addr_r = haddr_i;
        if (hsel_i && hready_i && htrans_i[1] && !hwrite_i) begin
            unique case (haddr_i)
                ADDR_CONTROL: s_nxt.rdata_r = {16'h0000, s_r.control_r};
                ADDR_COUNTER: s_nxt.rdata_r = {24'h000000, s_r.counter_r};
                ADDR_PERIOD: s_nxt.rdata_r = {24'h000000, s_r.period_r};
                ADDR_ACCESS: s_nxt.rdata_r = {16'h0000, 2'h0,
                    s_r.precharge_r, 11'h000, s_r.sdram_space_r};
                ADDR_STATUS: s_nxt.rdata_r = {24'h000000, 3'h0,
                    s_r.pending_r, 1'b0, s_r.state_r};
                default: s_nxt.rdata_r = 32'h00000000;
            endcase
        end

        // Hardware standby returns counter and period to their reset values
        if (hw_standby) begin
            s_nxt.counter_r = COUNTER_RESET;
            s_nxt.period_r = PERIOD_RESET;
        end
    end

    // State register; it loads the next state every cycle, in software standby too
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            s_r <= '0;
            s_r.counter_r <= COUNTER_RESET;
            s_r.period_r <= PERIOD_RESET;
            s_r.control_r <= CONTROL_RESET;
            s_r.state_r <= ST_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs
    assign hrdata_o = s_r.rdata_r;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign bus_request_o = s_r.pending_r;
    assign match_irq_o = s_r.control_r[MATCH_FLAG_BIT] && !refresh_en &&
        s_r.control_r[MATCH_IRQ_EN_BIT];
    assign strobe_o.cas = (s_r.state_r != ST_IDLE) &&
        (s_r.state_r != ST_PRECHARGE);
    assign strobe_o.ras = (s_r.state_r == ST_RAS);
    assign strobe_o.precharge = (s_r.state_r == ST_PRECHARGE);
    assign strobe_o.self_refresh = sw_standby && refresh_en &&
        s_r.control_r[SELF_REF_BIT];
    // Synchronous DRAM space ignores the parallel mode bit
    assign strobe_o.hold_other = strobe_o.busy &&
        (s_r.control_r[PARALLEL_BIT] || s_r.sdram_space_r);
    assign strobe_o.busy = (s_r.state_r != ST_IDLE);

endmodule

`default_nettype wire

// [dram_refresh_timer_asserts.sv]
// Checker with port-level properties of the refresh timer
`timescale 1ns/1ps
`default_nettype none

module dram_refresh_timer_asserts
    import refresh_timer_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Bus answer, arbitration and strobes
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic bus_grant_i,
    input wire logic bus_request_o,
    input wire refresh_strobe_t strobe_o,
    input wire logic match_irq_o
);
    // One domain, so clock and reset are given once
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    AST_BUS_OKAY: assert property (hreadyout_o && !hresp_o)
        else $error("bus answer not ready or not okay");
    AST_RESET_CLEAN: assert property ($past(!rst_n_i) |->
        hrdata_o == 32'h0 && !match_irq_o && strobe_o == '0)
        else $error("outputs not quiet after reset");
    AST_CAS_FIRST: assert property ($rose(strobe_o.cas) |-> !strobe_o.ras)
        else $error("row strobe with column strobe");
    AST_CAS_RAS_GAP: assert property ($rose(strobe_o.cas) |-> ##[1:4] strobe_o.ras)
        else $error("row strobe late after column strobe");
    AST_RAS_LEN: assert property ($rose(strobe_o.ras) |-> strobe_o.cas ##[1:4] !strobe_o.ras)
        else $error("row strobe length out of range");
    AST_PRE_AFTER_RAS: assert property ($fell(strobe_o.ras) |-> strobe_o.precharge && !strobe_o.cas)
        else $error("no precharge after row strobe");
    AST_PRE_LEN: assert property ($rose(strobe_o.precharge) |-> ##[1:11] !strobe_o.precharge)
        else $error("precharge too long");
    // Only a refresh cycle needs the grant; the post standby precharge does not
    AST_START_GRANT: assert property ($rose(strobe_o.cas) |-> $past(bus_request_o && bus_grant_i))
        else $error("refresh started without grant");
    AST_PENDING_HELD: assert property (bus_request_o && !bus_grant_i |=> bus_request_o)
        else $error("pending refresh dropped");
    AST_NO_IRQ_REFRESH: assert property (strobe_o.busy |-> !match_irq_o)
        else $error("interrupt during refresh");
    AST_HOLD: assert property (strobe_o.hold_other |-> strobe_o.busy)
        else $error("hold without refresh");

    // Main scenarios reached
    cover property ($rose(strobe_o.cas));
    cover property ($rose(match_irq_o));
    cover property ($rose(strobe_o.self_refresh));
    cover property (bus_request_o && !bus_grant_i);
endmodule

bind dram_refresh_timer dram_refresh_timer_asserts i_dram_refresh_timer_asserts (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .bus_grant_i(bus_grant_i),
    .bus_request_o(bus_request_o), .strobe_o(strobe_o),
    .match_irq_o(match_irq_o));

`default_nettype wire

// [ext_bus_model.sv]
// External bus owner that grants the bus to refresh cycles
`timescale 1ns/1ps
`default_nettype none

module ext_bus_model (
    // Clock and mode
    input wire logic clk_i,
    input wire logic slow_i,
    // Refresh handshake
    input wire logic request_i,
    input wire logic busy_i,
    output logic grant_o
);
    logic [3:0] wait_r = 4'h0;
    initial grant_o = 1'b0;
    // Slow mode keeps the bus occupied for 8 cycles, so the request waits
    always @(posedge clk_i) begin
        wait_r <= request_i ? wait_r + 4'h1 : 4'h0;
        grant_o <= busy_i | (request_i & (!slow_i | wait_r[3]));
    end
endmodule

`default_nettype wire

// [dram_refresh_timer_tb.sv]
// Testbench driving the refresh timer through its register bus
`timescale 1ns/1ps
`default_nettype none

module dram_refresh_timer_tb;
    import refresh_timer_pkg::*;
    logic clk, rst_n, hw_sb, sw_sb, hsel, hwrite, grant, req, irq, slow;
    logic hreadyout, hresp;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, r, c;
    refresh_strobe_t strobe;
    int miscompares = 0, n_compared = 0, cycles = 0;

    dram_refresh_timer i_dram_refresh_timer (.sys_clk_i(clk), .rst_n_i(rst_n),
        .hw_standby_i(hw_sb), .sw_standby_i(sw_sb), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout),
        .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
        .bus_grant_i(grant), .bus_request_o(req), .strobe_o(strobe),
        .match_irq_o(irq));
    ext_bus_model i_ext_bus_model (.clk_i(clk), .slow_i(slow),
        .request_i(req), .busy_i(strobe.busy), .grant_o(grant));

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Hang guard: the tests need a few thousand cycles at most
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            results();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Single word transfer: address phase, then data phase
    task automatic ahb(input logic [7:0] a, input logic w,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(a, 1'b1, d, x);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        ahb(a, 1'b0, 32'h0, x);
        check(x, e);
    endtask

    task automatic done(input string name);
        $display("Test %s finished", name);
    endtask

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        {rst_n, hw_sb, sw_sb, hsel, hwrite, slow} = 6'h0;
        haddr = 8'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values and an unmapped place
        rd_chk(ADDR_CONTROL, 32'h0);
        rd_chk(ADDR_COUNTER, 32'h0);
        rd_chk(ADDR_PERIOD, 32'hff);
        rd_chk(8'h14, 32'h0);
        done("reset");
        // Interval timer: reserved bit 11 always written as zero
        wr(ADDR_PERIOD, 32'h40);
        wr(ADDR_CONTROL, 32'h4100);
        for (int i = 0; i < 400 && irq !== 1'b1; i++) @(negedge clk);
        check({31'h0, irq}, 32'h1);
        rd_chk(ADDR_CONTROL, 32'hc100);
        wr(ADDR_CONTROL, 32'hc100);
        rd_chk(ADDR_CONTROL, 32'hc100);
        wr(ADDR_CONTROL, 32'h4000);
        rd_chk(ADDR_CONTROL, 32'h4000);
        check({31'h0, irq}, 32'h0);
        wr(ADDR_COUNTER, 32'h12);
        repeat (20) @(posedge clk);
        rd_chk(ADDR_COUNTER, 32'h12);
        done("interval");
        // Refresh with slow grant: waits 3, refresh wait 1, precharge 4
        slow <= 1'b1;
        wr(ADDR_ACCESS, 32'h3000);
        rd_chk(ADDR_ACCESS, 32'h3000);
        wr(ADDR_COUNTER, 32'h0);
        wr(ADDR_CONTROL, 32'h7190);
        rd_chk(ADDR_CONTROL, 32'h3190);
        for (int i = 0; i < 400 && strobe.cas !== 1'b1; i++) @(negedge clk);
        for (c = 0; strobe.ras !== 1'b1; c++) @(negedge clk);
        check(c, 32'h4);
        check({31'h0, strobe.hold_other}, 32'h0);
        for (c = 0; strobe.ras === 1'b1; c++) @(negedge clk);
        check(c, 32'h2);
        for (c = 0; strobe.precharge === 1'b1; c++) @(negedge clk);
        check(c, 32'h4);
        rd_chk(ADDR_CONTROL, 32'h3190);
        done("refresh");
        // Self refresh in software standby, bit cleared on exit
        wr(ADDR_CONTROL, 32'h3198);
        sw_sb <= 1'b1;
        repeat (5) @(negedge clk);
        check({31'h0, strobe.self_refresh}, 32'h1);
        @(posedge clk);
        sw_sb <= 1'b0;
        repeat (8) @(posedge clk);
        rd_chk(ADDR_CONTROL, 32'h3190);
        done("self_refresh");
        // Hardware standby returns counter and period to reset values
        hw_sb <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(ADDR_COUNTER, 32'h0);
        rd_chk(ADDR_PERIOD, 32'hff);
        hw_sb <= 1'b0;
        done("hw_standby");
        results();
    end
endmodule

`default_nettype wire
